// ---- design/pin_sync.sv ----
// Three-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Raw pins
  input wire logic [WIDTH-1:0] pins_in,
  // Second and third stages; a change counts once they agree
  output logic [WIDTH-1:0] stage2_out,
  output logic [WIDTH-1:0] stage3_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_q, s2_q, s3_q;
      // First stage is read only by the second
      always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
          s1_q <= RESET_VAL[i];
          s2_q <= RESET_VAL[i];
          s3_q <= RESET_VAL[i];
        end else begin
          s1_q <= pins_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign stage2_out[i] = s2_q;
      assign stage3_out[i] = s3_q;
    end
  endgenerate
endmodule // pin_sync

// ---- design/spi_pin_and_select_logic.sv ----
// Serial port pin drive, select modes and byte shifting behind an AXI4-Lite slave
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "spi_pin_consts.svh"
module spi_pin_and_select_logic
  import spi_pin_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  // Master-to-slave data pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  // Slave-to-master data pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  // Select pin and its routing
  input wire logic sel_b_in,
  output logic sel_b_out,
  output logic sel_b_oe_out,
  output logic sel_pin_mapped_out
);
  // Control and status state
  logic en_q, mst_q;
  logic [1:0] mode_q;
  logic [7:0] div_q, div_cnt_q;
  logic done_q, mode_fault_flag_q, wcol_q, ovr_q;
  // Data path state
  byte_t tx_q, sr_q, rx_q;
  logic tx_full_q, sr_full_q, rx_unread_q, bit_q;
  logic [2:0] cnt_q;
  logic sck_q, sck_lvl_q, sel_lvl_q;
  // Bus state
  logic bvalid_q, rvalid_q;
  resp_t bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Synchronised pins: {sck, mosi, miso, select}
  logic [3:0] s2, s3;

  pin_sync #(
    .WIDTH(4),
    .RESET_VAL(`SYNC_RESET)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .pins_in({sck_in, mosi_in, miso_in, sel_b_in}),
    .stage2_out(s2),
    .stage3_out(s3)
  );

  // Bus decode
  logic wr_hs, rd_hs, wr_ok, rd_ok;
  reg_sel_e wr_sel, rd_sel;
  logic wr_ctrl, wr_stat, wr_data, wr_div, rd_data;
  assign s_axi_awready_out = s_axi_awvalid_in & s_axi_wvalid_in & ~bvalid_q;
  assign s_axi_wready_out = s_axi_awready_out;
  assign s_axi_arready_out = ~rvalid_q;
  assign wr_hs = s_axi_awready_out;
  assign rd_hs = s_axi_arvalid_in & ~rvalid_q;
  always_comb begin
    wr_ok = reg_hit(s_axi_awaddr_in, wr_sel);
    rd_ok = reg_hit(s_axi_araddr_in, rd_sel);
  end
  // Only the low byte lane carries register data
  assign wr_ctrl = wr_hs & wr_ok & s_axi_wstrb_in[0] & (wr_sel == REG_CTRL);
  assign wr_stat = wr_hs & wr_ok & s_axi_wstrb_in[0] & (wr_sel == REG_STAT);
  assign wr_data = wr_hs & wr_ok & s_axi_wstrb_in[0] & (wr_sel == REG_DATA);
  assign wr_div = wr_hs & wr_ok & s_axi_wstrb_in[0] & (wr_sel == REG_DIV);
  assign rd_data = rd_hs & rd_ok & (rd_sel == REG_DATA);

  // Role and select decode
  logic is_master, is_slave, four_in, selected, mode_fault_flag_evt;
  assign is_master = en_q & mst_q;
  assign is_slave = en_q & ~mst_q;
  // select input only in mode 01
  assign four_in = (mode_q == `MODE_4WIRE_IN);
  // no select input means always selected
  assign selected = ~four_in | ~sel_lvl_q;
  // select pulled low disables the master
  assign mode_fault_flag_evt = is_master & four_in & ~sel_lvl_q;

  // Accepted select level; as slave in mode 01 the falling edge resets the bit counter
  logic sel_fall;
  assign sel_fall = (s2[0] == s3[0]) & ~s3[0] & sel_lvl_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sel_lvl_q <= 1'b1;
    end else if (s2[0] == s3[0]) begin
      sel_lvl_q <= s3[0];
    end
  end

  // Slave clock edges; level tracks even when ignored so no stale edge fires later
  logic sck_ok, s_rise, s_fall;
  assign sck_ok = (s2[3] == s3[3]);
  assign s_rise = is_slave & selected & sck_ok & s3[3] & ~sck_lvl_q;
  assign s_fall = is_slave & selected & sck_ok & ~s3[3] & sck_lvl_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sck_lvl_q <= 1'b0;
    end else if (sck_ok) begin
      sck_lvl_q <= s3[3];
    end
  end

  // Master clock divider; runs only while a byte is in flight
  logic m_busy, tick, m_rise, m_fall;
  assign m_busy = is_master & (sr_full_q | sck_q);
  assign tick = m_busy & (div_cnt_q == div_q);
  assign m_rise = tick & ~sck_q;
  assign m_fall = tick & sck_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || !m_busy || tick) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // clock made here only as master
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || !is_master) begin
      sck_q <= 1'b0;
    end else if (tick) begin
      sck_q <= ~sck_q;
    end
  end

  // Common shift events for both roles
  logic rise, fall, in_bit, byte_done, move;
  byte_t rx_byte;
  assign rise = m_rise | s_rise;
  assign fall = m_fall | s_fall;
  assign in_bit = mst_q ? s3[1] : s3[2];
  // eighth sampling edge ends the byte
  assign byte_done = rise & (cnt_q == `LAST_BIT);
  // first bit received lands at the top
  assign rx_byte = {sr_q[6:0], in_bit};
  assign move = tx_full_q & ~sr_full_q & (cnt_q == 3'h0) & ~sck_q & ~byte_done;

  // Bit counter
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || !en_q) begin
      cnt_q <= 3'h0;
    end else if (is_slave & four_in & sel_fall) begin
      cnt_q <= 3'h0;
    end else if (rise) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Bit sampled on the leading edge, shifted in on the trailing one
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      bit_q <= 1'b0;
    end else if (rise) begin
      bit_q <= in_bit;
    end
  end

  // Shift register; the last bit stands through its sampling edge, reload waits for sck low
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sr_q <= 8'h00;
      sr_full_q <= 1'b0;
    end else if (!en_q) begin
      sr_full_q <= 1'b0;
    end else if (byte_done) begin
      sr_full_q <= 1'b0;
    // shifting toward the top sends MSB first
    end else if (fall && cnt_q != 3'h0) begin
      sr_q <= {sr_q[6:0], bit_q};
    // empty shift register takes the buffer once sck is low and the bit count is zero
    end else if (move) begin
      sr_q <= tx_q;
      sr_full_q <= 1'b1;
    end
  end

  // Transmit buffer; a write while full is dropped and flagged
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      tx_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (!en_q) begin
      tx_full_q <= 1'b0;
    end else if (wr_data && !tx_full_q) begin
      tx_q <= s_axi_wdata_in[7:0];
      tx_full_q <= 1'b1;
    end else if (move) begin
      tx_full_q <= 1'b0;
    end
  end

  // Receive buffer; as slave an unread byte is kept and the new one lost
  logic ovr_evt;
  assign ovr_evt = byte_done & is_slave & rx_unread_q;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rx_q <= 8'h00;
      rx_unread_q <= 1'b0;
    // finished byte copied to receive buffer
    end else if (byte_done && !ovr_evt) begin
      rx_q <= rx_byte;
      rx_unread_q <= 1'b1;
    end else if (rd_data) begin
      rx_unread_q <= 1'b0;
    end
  end

  // Control register; a mode fault beats a simultaneous software write
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      en_q <= 1'b0;
      mst_q <= 1'b0;
      mode_q <= `MODE_RESET;
      div_q <= `DIV_RESET;
    end else begin
      if (wr_ctrl) begin
        en_q <= s_axi_wdata_in[`CTRL_EN_BIT];
        mst_q <= s_axi_wdata_in[`CTRL_MST_BIT];
        mode_q <= s_axi_wdata_in[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
      end
      if (mode_fault_flag_evt) begin
        en_q <= 1'b0;
        mst_q <= 1'b0;
      end
      if (wr_div) begin
        div_q <= s_axi_wdata_in[7:0];
      end
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  logic [3:0] w1c;
  assign w1c = wr_stat ? s_axi_wdata_in[3:0] : 4'h0;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      done_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      wcol_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      done_q <= byte_done | (done_q & ~w1c[`STAT_DONE_BIT]);
      mode_fault_flag_q <= mode_fault_flag_evt | (mode_fault_flag_q & ~w1c[`STAT_MODE_FAULT_FLAG_BIT]);
      wcol_q <= (wr_data & tx_full_q) | (wcol_q & ~w1c[`STAT_WCOL_BIT]);
      ovr_q <= ovr_evt | (ovr_q & ~w1c[`STAT_OVR_BIT]);
    end
  end

  // Status word
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0;
    stat_word[`STAT_DONE_BIT] = done_q;
    stat_word[`STAT_MODE_FAULT_FLAG_BIT] = mode_fault_flag_q;
    stat_word[`STAT_WCOL_BIT] = wcol_q;
    stat_word[`STAT_OVR_BIT] = ovr_q;
    stat_word[`STAT_BUSY_BIT] = m_busy | (is_slave & (cnt_q != 3'h0));
    stat_word[`STAT_TXFULL_BIT] = tx_full_q;
    stat_word[`STAT_SEL_BIT] = sel_lvl_q;
  end

  // Write response, one cycle after both channels are taken
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (wr_hs) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data, registered; reading the data register frees the receive buffer
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0;
    end else if (rd_hs) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      rdata_q <= 32'h0;
      if (rd_ok) begin
        case (rd_sel)
          REG_CTRL: rdata_q[3:0] <= {mode_q, mst_q, en_q};
          REG_STAT: rdata_q <= stat_word;
          REG_DATA: rdata_q[7:0] <= rx_q;
          default: rdata_q[7:0] <= div_q;
        endcase
      end
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = rdata_q;

  // Pin drive
  assign sck_out = sck_q;
  assign sck_oe_out = is_master;
  assign mosi_out = sr_q[7];
  assign mosi_oe_out = is_master;
  assign miso_out = sr_q[7];
  assign miso_oe_out = is_slave & selected;
  // select output follows the low mode bit
  assign sel_b_out = mode_q[0];
  assign sel_b_oe_out = en_q & mode_q[1];
  // no select pin in 3-wire mode
  assign sel_pin_mapped_out = (mode_q != `MODE_3WIRE);
endmodule // spi_pin_and_select_logic

// ---- design/spi_pin_consts.svh ----
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SPI_PIN_CONSTS_SVH
`define SPI_PIN_CONSTS_SVH

// Byte addresses on the register bus
`define CTRL_ADDR 4'h0
`define STAT_ADDR 4'h4
`define DATA_ADDR 4'h8
`define DIV_ADDR 4'hC

// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_MST_BIT 1
`define CTRL_MODE_LSB 2

// Status register fields, the low four are write-one-to-clear
`define STAT_DONE_BIT 0
`define STAT_MODE_FAULT_FLAG_BIT 1
`define STAT_WCOL_BIT 2
`define STAT_OVR_BIT 3
`define STAT_BUSY_BIT 4
`define STAT_TXFULL_BIT 5
`define STAT_SEL_BIT 6

// Reset values
`define MODE_RESET 2'h1
`define DIV_RESET 8'h03
`define SYNC_RESET 4'h1

// Select mode codes
`define MODE_3WIRE 2'h0
`define MODE_4WIRE_IN 2'h1

// Bits per byte, and the counter value of the last bit
`define BYTE_BITS 8
`define LAST_BIT 3'h7

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- design/spi_pin_pkg.sv ----
// Types shared by the serial port design
package spi_pin_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] resp_t;
  typedef enum logic [1:0] {REG_CTRL, REG_STAT, REG_DATA, REG_DIV} reg_sel_e;

  // Maps a byte address to a register, flags unmapped ones
  function automatic logic reg_hit(input logic [3:0] addr, output reg_sel_e sel);
    sel = REG_CTRL;
    reg_hit = (addr[1:0] == 2'h0);
    case (addr[3:2])
      2'h0: sel = REG_CTRL;
      2'h1: sel = REG_STAT;
      2'h2: sel = REG_DATA;
      default: sel = REG_DIV;
    endcase
  endfunction
endpackage

// ---- sim/spi_far_end.sv ----
// Far-side serial device: slave while the port leads, master otherwise
`timescale 1ns/1ps
module spi_far_end (
  // Resolved lines
  input wire logic sck_line_in,
  input wire logic mosi_line_in,
  input wire logic miso_line_in,
  // Far-side drive and last byte seen
  output logic sck_out,
  output logic mosi_out,
  output logic miso_out,
  output logic sel_b_out,
  output logic [7:0] got_out
);
  logic [7:0] tx_q = 8'h00;
  logic lead_q = 1'h0;
  logic bit_q = 1'h0;
  initial begin
    sck_out = 1'h0;
    sel_b_out = 1'h1;
    got_out = 8'h00;
  end
  // sample each bit on the rise
  always @(posedge sck_line_in) got_out <= {got_out[6:0], lead_q ? miso_line_in : mosi_line_in};
  // lone slave shifts on the fall
  always @(negedge sck_line_in) if (!lead_q) tx_q <= {tx_q[6:0], 1'h0};
  // Undriven lines show a changing pattern, not the last value
  assign mosi_out = lead_q ? bit_q : ~got_out[0];
  assign miso_out = lead_q ? ~sck_out : tx_q[7];
  // select leads first edge by 12 clocks
  // Pin changes fall between system clock edges so the synchronisers see them cleanly
  task automatic xfer(input logic [7:0] m, input logic stay_off);
    #12.5;
    lead_q = 1'h1;
    sel_b_out = stay_off;
    #200;
    for (int i = 7; i >= 0; i--) begin
      bit_q = m[i];
      #100 sck_out = 1'h1;
      #100 sck_out = 1'h0;
    end
    #100;
    sel_b_out = 1'h1;
    lead_q = 1'h0;
    #12.5;
  endtask
endmodule // spi_far_end

// ---- sim/spi_pin_and_select_logic_assertions.sv ----
// Checker for pin drive, select routing and clocking at the serial port pins
`timescale 1ns/1ps
module spi_pin_and_select_logic_assertions (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Watched ports
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic sel_b_in,
  input wire logic sck_out,
  input wire logic sck_oe_out,
  input wire logic mosi_out,
  input wire logic mosi_oe_out,
  input wire logic miso_out,
  input wire logic miso_oe_out,
  input wire logic sel_b_oe_out,
  input wire logic sel_pin_mapped_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  pair_drive_a: assert property (sck_oe_out == mosi_oe_out)
    else $error("clock and data-out drive differ");
  one_driver_a: assert property (!(miso_oe_out && mosi_oe_out))
    else $error("both data pins driven");
  sel_map_a: assert property (sel_b_oe_out |-> sel_pin_mapped_out)
    else $error("select driven but not routed");
  mosi_setup_a: assert property (sck_oe_out && $rose(sck_out) |-> $stable(mosi_out))
    else $error("data-out moved at clock rise");
  fault_drop_a: assert property (sck_oe_out && sel_pin_mapped_out && !sel_b_oe_out && !sel_b_in
    |-> ##[1:6] !sck_oe_out)
    else $error("master kept after select low");
  miso_release_a: assert property ((sel_pin_mapped_out && !sel_b_oe_out && sel_b_in)[*7]
    |-> !miso_oe_out)
    else $error("slave output driven while deselected");
  desel_hold_a: assert property ((sel_pin_mapped_out && !sel_b_oe_out && sel_b_in && !sck_oe_out
    && !s_axi_wvalid_in)[*8] |-> $stable(miso_out))
    else $error("deselected slave shifted");
  start_a: assert property (sck_oe_out && s_axi_awvalid_in && s_axi_awready_out
    && s_axi_awaddr_in == 4'h8 |-> ##[2:24] sck_out)
    else $error("no clock after data write");
endmodule // spi_pin_and_select_logic_assertions

bind spi_pin_and_select_logic spi_pin_and_select_logic_assertions chk (.*);

// ---- sim/spi_pin_and_select_logic_tb.sv ----
// Self-checking bench for the serial port pin and select logic
`timescale 1ns/1ps
module spi_pin_and_select_logic_tb;
  logic clk_sys_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [3:0] s_axi_awaddr_in = 4'h0, s_axi_wstrb_in = 4'h0, s_axi_araddr_in = 4'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd_q;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, sck_in, sck_out, sck_oe_out, mosi_in, mosi_out, mosi_oe_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp_q;
  logic miso_in, miso_out, miso_oe_out, sel_b_in, sel_b_out, sel_b_oe_out, sel_pin_mapped_out;
  logic f_sck, f_mosi, f_miso, f_sel;
  logic [7:0] f_got, b, e;
  int seed = 18, miscompares = 0, compares = 0, cyc = 0;
  // System clock, 25 ns period
  always #12.5 clk_sys_in = ~clk_sys_in;
  // Wire levels from every driver's enable
  assign sck_in = sck_oe_out ? sck_out : f_sck;
  assign mosi_in = mosi_oe_out ? mosi_out : f_mosi;
  assign miso_in = miso_oe_out ? miso_out : f_miso;
  assign sel_b_in = sel_b_oe_out ? sel_b_out : f_sel;
  spi_pin_and_select_logic uut (.*);
  spi_far_end far (.sck_line_in(sck_in), .mosi_line_in(mosi_in), .miso_line_in(miso_in),
    .sck_out(f_sck), .mosi_out(f_mosi), .miso_out(f_miso), .sel_b_out(f_sel), .got_out(f_got));
  // Control word from its fields
  function automatic logic [31:0] cw(input logic en, input logic mst, input logic [1:0] md);
    return {28'h0, md, mst, en};
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  // Bus write: address and data offered together, held until taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= 4'hF;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    do @(posedge clk_sys_in); while (s_axi_awready_out !== 1'h1 || s_axi_wready_out !== 1'h1);
    s_axi_awvalid_in <= 1'h0;
    s_axi_wvalid_in <= 1'h0;
    do @(posedge clk_sys_in); while (s_axi_bvalid_out !== 1'h1);
    rsp_q = s_axi_bresp_out;
    s_axi_bready_in <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'h1);
    s_axi_arvalid_in <= 1'h0;
    do @(posedge clk_sys_in); while (s_axi_rvalid_out !== 1'h1);
    rd_q = s_axi_rdata_out;
    rsp_q = s_axi_rresp_out;
    s_axi_rready_in <= 1'h0;
  endtask
  task automatic wait_done;
    do rd(4'h4); while (rd_q[0] !== 1'h1);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'h1;
    rd(4'h0);
    chk("ctrl reset", 32'h4, rd_q);
    chk("pins reset", 32'h8, {sel_pin_mapped_out, sck_oe_out, mosi_oe_out, miso_oe_out});
    rd(4'h2);
    chk("unaligned", 32'h2, rsp_q);
    // Divider kept at 3 or more: the master samples its data-in through the synchroniser
    e = 8'h03 + {6'h0, 2'($random(seed))};
    wr(4'hC, {24'h0, e});
    rd(4'hC);
    chk("divider", e, rd_q);
    $display("registers done");
    // Master bytes in every select mode; output mode only as master
    for (int m = 0; m < 4; m++) begin
      b = 8'($random(seed));
      e = 8'($random(seed));
      far.tx_q = e;
      wr(4'h0, cw(1'h1, 1'h1, m[1:0]));
      wr(4'h8, {24'h0, b});
      wait_done();
      chk("far rx", b, f_got);
      rd(4'h8);
      chk("master rx", e, rd_q);
      chk("select pin", {m != 0, m[1], m[0]}, {sel_pin_mapped_out, sel_b_oe_out, sel_b_out});
      wr(4'h4, 32'hF);
    end
    $display("master done");
    // Third quick write finds the buffer full
    wr(4'h0, cw(1'h1, 1'h1, 2'h1));
    b = 8'($random(seed));
    wr(4'h8, 32'h3C);
    wr(4'h8, {24'h0, b});
    wr(4'h8, 32'hFF);
    rd(4'h4);
    chk("collision", 32'h1, rd_q[2]);
    wait_done();
    wr(4'h4, 32'hF);
    wait_done();
    chk("queued byte", b, f_got);
    wr(4'h4, 32'hF);
    // Far side had shifted out its byte already; reading also frees the buffer for slave use
    rd(4'h8);
    chk("queued rx", 32'h0, rd_q);
    // Another master pulls select low; the sync chain takes three clocks
    far.sel_b_out <= 1'h0;
    repeat (8) @(posedge clk_sys_in);
    rd(4'h0);
    chk("fault ctrl", cw(1'h0, 1'h0, 2'h1), rd_q);
    rd(4'h4);
    chk("fault flag", 32'h1, rd_q[1]);
    far.sel_b_out <= 1'h1;
    wr(4'h4, 32'hF);
    $display("fault done");
    // Slave in 3-wire then 4-wire; disabling clears the bit count
    for (int m = 0; m < 2; m++) begin
      wr(4'h0, 32'h0);
      wr(4'h0, cw(1'h1, 1'h0, m[1:0]));
      b = 8'($random(seed));
      e = 8'($random(seed));
      wr(4'h8, {24'h0, b});
      chk("slave drive", m == 0, miso_oe_out);
      if (m == 1) far.xfer(8'h55, 1'h1);
      far.xfer(e, 1'h0);
      wait_done();
      chk("slave tx", b, f_got);
      rd(4'h8);
      chk("slave rx", e, rd_q);
      wr(4'h4, 32'hF);
    end
    $display("slave done");
    results();
  end
  // Cycle ceiling cuts a hang short
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule // spi_pin_and_select_logic_tb
